// file: common/tcuc_map.svh
// Register offsets, field positions and reset values of the timer core.
// Assumes word-indexed Avalon-MM addressing; included by logic and test files.
`ifndef TCUC_MAP_SVH
`define TCUC_MAP_SVH

// ----------------------------------------
// Register word indexes
// ----------------------------------------
`define TCUC_OFS_CTRL 3'h0
`define TCUC_OFS_TRIG 3'h1
`define TCUC_OFS_CNT 3'h2
`define TCUC_OFS_DIV 3'h3
`define TCUC_OFS_PER 3'h4
`define TCUC_OFS_STAT 3'h5
`define TCUC_OFS_SWEV 3'h6

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TCUC_CTRL_EN 0
`define TCUC_CTRL_OVDIS 1
`define TCUC_CTRL_OVSRC 2
`define TCUC_CTRL_DIR 3
`define TCUC_CTRL_ALN 4
`define TCUC_CTRL_PBE 7
`define TCUC_CTRL_RESET 8'h00

// ----------------------------------------
// Trigger register fields
// ----------------------------------------
`define TCUC_TRIG_SMS 0
`define TCUC_TRIG_TSS 4
`define TCUC_TRIG_EPOL 7
`define TCUC_TRIG_EPSC 8
`define TCUC_TRIG_EFLT 10
`define TCUC_TRIG_ECMB 14
`define TCUC_TRIG_C1POL 15
`define TCUC_TRIG_C2POL 16
`define TCUC_TRIG_C1FLT 20
`define TCUC_TRIG_C2FLT 24
`define TCUC_TRIG_RESET 28'h0000000

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define TCUC_SMS_EXTA 3'h7
`define TCUC_TSS_CH1BE 3'h4
`define TCUC_TSS_CH1F 3'h5
`define TCUC_TSS_CH2F 3'h6
`define TCUC_TSS_EXT 3'h7
`define TCUC_ALN_EDGE 2'h0
`define TCUC_WORD_RESET 16'h0000
`define TCUC_STAT_FLAG 0
`define TCUC_SWEV_TRIG 0

`endif

// file: common/tcuc_pkg.sv
// Types shared by the timer core and its trigger conditioner.
// Assumes the map header is on the include path.
package tcuc_pkg;
  typedef logic [15:0] tcuc_word_t;
  typedef enum logic [1:0] {TCUC_SRC_INT, TCUC_SRC_EXTA, TCUC_SRC_EXTB} tcuc_src_e;
  typedef struct packed {
    logic [2:0] trigger_source_select;
    logic outside_signal_polarity;
    logic [1:0] outside_signal_prescale;
    logic [3:0] outside_signal_filter;
    logic ext_clock_b_enable;
    logic ch1_polarity;
    logic ch2_polarity;
    logic [3:0] ch1_input_filter;
    logic [3:0] ch2_input_filter;
  } tcuc_trig_cfg_s;
endpackage : tcuc_pkg

// file: common/tcuc_cfg_if.sv
// Carrier between the timer core and its trigger conditioner.
// Assumes both ends run on the same kernel clock.
`timescale 1ns/1ps
interface tcuc_cfg_if;
  import tcuc_pkg::*;
  tcuc_trig_cfg_s cfg;
  logic ext_tick;
  modport ctrl (output cfg, input ext_tick);
  modport cond (input cfg, output ext_tick);
endinterface : tcuc_cfg_if

// file: logic/tcuc_trig_cond.sv
// Trigger conditioner: synchroniser, polarity, divider, filters and source mux.
// Assumes pins are asynchronous to ref_clk; emits one pulse per active edge.
`timescale 1ns/1ps
`include "tcuc_map.svh"
module tcuc_trig_cond (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ch1_pin,
  input wire logic ch2_pin,
  input wire logic ext_pin,
  input wire logic [3:0] internal_trigger_line,
  tcuc_cfg_if.cond cfg_if
);
  import tcuc_pkg::*;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [6:0] sync1_ff;
  logic [6:0] sync2_ff;
  wire [6:0] raw_in = {internal_trigger_line, ext_pin, ch2_pin, ch1_pin};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------
  // Outside pin: polarity then division
  // ----------------------------------------
  logic ext_prev_ff;
  logic [2:0] ext_div_ff;
  wire ext_pol = sync2_ff[2] ^ cfg_if.cfg.outside_signal_polarity;
  wire [1:0] psc = cfg_if.cfg.outside_signal_prescale;
  wire ext_divided = (psc == 2'h0) ? ext_pol : ext_div_ff[psc - 2'h1];
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ext_prev_ff <= 1'b0;
      ext_div_ff <= 3'h0;
    end else begin
      ext_prev_ff <= ext_pol;
      if (ext_pol && !ext_prev_ff) begin
        ext_div_ff <= ext_div_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Filters: a change passes once it held for code+1 samples
  // ----------------------------------------
  wire [2:0] flt_in = {ext_divided, sync2_ff[1], sync2_ff[0]};
  wire [11:0] flt_code = {cfg_if.cfg.outside_signal_filter, cfg_if.cfg.ch2_input_filter,
                          cfg_if.cfg.ch1_input_filter};
  logic [2:0] flt_out;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_flt
      logic [3:0] cnt_ff;
      logic out_ff;
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          cnt_ff <= 4'h0;
          out_ff <= 1'b0;
        end else if (flt_in[gi] == out_ff) begin
          cnt_ff <= 4'h0;
        end else if (cnt_ff >= flt_code[gi*4 +: 4]) begin
          out_ff <= flt_in[gi];
          cnt_ff <= 4'h0;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
      assign flt_out[gi] = out_ff;
    end
  endgenerate

  // ----------------------------------------
  // Source selection and edge pulse
  // ----------------------------------------
  wire ch1_both_edge_input = flt_out[0];
  wire ch1_filtered_input = flt_out[0] ^ cfg_if.cfg.ch1_polarity;
  wire ch2_filtered_input = flt_out[1] ^ cfg_if.cfg.ch2_polarity;
  wire ext_cond = flt_out[2];
  // Mode B forces the outside pin, same path as mode A with that source
  wire [2:0] sel = cfg_if.cfg.ext_clock_b_enable ? `TCUC_TSS_EXT
                   : cfg_if.cfg.trigger_source_select;
  wire trigger_input = (sel == `TCUC_TSS_CH1BE) ? ch1_both_edge_input :
                       (sel == `TCUC_TSS_CH1F) ? ch1_filtered_input :
                       (sel == `TCUC_TSS_CH2F) ? ch2_filtered_input :
                       (sel == `TCUC_TSS_EXT) ? ext_cond :
                       sync2_ff[3 + sel[1:0]];
  logic trig_prev_ff;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trig_prev_ff <= 1'b0;
    end else begin
      trig_prev_ff <= trigger_input;
    end
  end
  assign cfg_if.ext_tick = (sel == `TCUC_TSS_CH1BE) ? (trigger_input ^ trig_prev_ff)
                           : (trigger_input & ~trig_prev_ff);

  a_tick_on_edge: assert property (@(posedge ref_clk) disable iff (!rstn)
    cfg_if.ext_tick |-> (trigger_input != trig_prev_ff))
    else $error("tick without an input edge");
endmodule : tcuc_trig_cond

// file: logic/tcuc_top.sv
// Timer clock selection, prescaler, period shadowing and up/down counting core.
// Assumes ref_clk is the kernel clock and an Avalon-MM master drives the bus.
//
// Behaviour
// - Internal tick every cycle, or every other cycle when bus prescaler is one.
// - Slave mode 3'b111 counts on the selected trigger input.
// - Trigger codes 4..7 pick ch1 both edges, ch1, ch2, outside pin.
// - Mode B counts the outside pin after polarity, division, filtering.
// - Mode B equals mode A with the outside pin selected.
// - Trigger codes 0..3 pick internal trigger lines 0..3.
// - Internal trigger in mode A lets another timer clock this one.
// - Counter advances once every prescaler value plus one source ticks.
// - Prescaler writes take effect only at the next overflow event.
// - Period copies immediately, or at overflow event when buffering enabled.
// - Counter reads live value; a write replaces it at once.
// - Overflow events enabled after reset, blocked while disable bit set.
// - Source select clear: wrap, software or slave reset; set: wrap only.
// - Run signal follows the enable bit one cycle later.
// - Upcount 0 to period, wrap to 0, raise event and flag.
// - Without events, no prescaler or buffered period reload; with events, shadows reload each event.
// - Outside clocks pass a synchroniser, delaying the tick.
// - Direction one: count down period to 0, reload period, underflow event.
// - Counter stays stopped while active period is zero.
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "tcuc_map.svh"
module tcuc_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bus_presc_is_one,
  input wire logic ch1_pin,
  input wire logic ch2_pin,
  input wire logic ext_pin,
  input wire logic [3:0] internal_trigger_line,
  input wire logic slave_reset_req,
  output tcuc_pkg::tcuc_word_t counter_value,
  output logic overflow_event,
  output logic counter_run_sync
);
  import tcuc_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] tcuc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : tcuc_merge

  // ----------------------------------------
  // Bus slave: one wait state on every access
  // ----------------------------------------
  logic ack_ff;
  logic [31:0] rdata_ff;
  wire req = avs_read | avs_write;
  wire wr_go = avs_write & ack_ff;
  wire wr_ctrl = wr_go & (avs_address == `TCUC_OFS_CTRL);
  wire wr_trig = wr_go & (avs_address == `TCUC_OFS_TRIG);
  wire wr_cnt = wr_go & (avs_address == `TCUC_OFS_CNT);
  wire wr_div = wr_go & (avs_address == `TCUC_OFS_DIV);
  wire wr_per = wr_go & (avs_address == `TCUC_OFS_PER);
  wire wr_stat = wr_go & (avs_address == `TCUC_OFS_STAT);
  wire wr_swev = wr_go & (avs_address == `TCUC_OFS_SWEV);
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [7:0] ctrl_ff;
  logic [27:0] trig_ff;
  tcuc_word_t div_ff;
  tcuc_word_t per_ff;
  wire [31:0] ctrl_m = tcuc_merge({24'h000000, ctrl_ff}, avs_writedata, avs_byteenable);
  wire [31:0] trig_m = tcuc_merge({4'h0, trig_ff}, avs_writedata, avs_byteenable);
  wire [31:0] div_m = tcuc_merge({16'h0000, div_ff}, avs_writedata, avs_byteenable);
  wire [31:0] per_m = tcuc_merge({16'h0000, per_ff}, avs_writedata, avs_byteenable);
  wire [7:0] nxt_ctrl = wr_ctrl ? ctrl_m[7:0] : ctrl_ff;
  wire [27:0] nxt_trig = wr_trig ? trig_m[27:0] : trig_ff;
  wire [15:0] nxt_div = wr_div ? div_m[15:0] : div_ff;
  wire [15:0] nxt_per = wr_per ? per_m[15:0] : per_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= `TCUC_CTRL_RESET;
      trig_ff <= `TCUC_TRIG_RESET;
      div_ff <= `TCUC_WORD_RESET;
      per_ff <= `TCUC_WORD_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
      trig_ff <= nxt_trig;
      div_ff <= nxt_div;
      per_ff <= nxt_per;
    end
  end

  wire timer_enable_bit = ctrl_ff[`TCUC_CTRL_EN];
  wire overflow_event_disable = ctrl_ff[`TCUC_CTRL_OVDIS];
  wire overflow_source_select = ctrl_ff[`TCUC_CTRL_OVSRC];
  wire count_direction_bit = ctrl_ff[`TCUC_CTRL_DIR];
  wire [1:0] count_alignment_select = ctrl_ff[`TCUC_CTRL_ALN +: 2];
  wire period_buffer_enable = ctrl_ff[`TCUC_CTRL_PBE];
  wire [2:0] slave_mode_select = trig_ff[`TCUC_TRIG_SMS +: 3];

  // ----------------------------------------
  // Trigger conditioner
  // ----------------------------------------
  tcuc_cfg_if cfg_bus ();
  assign cfg_bus.cfg.trigger_source_select = trig_ff[`TCUC_TRIG_TSS +: 3];
  assign cfg_bus.cfg.outside_signal_polarity = trig_ff[`TCUC_TRIG_EPOL];
  assign cfg_bus.cfg.outside_signal_prescale = trig_ff[`TCUC_TRIG_EPSC +: 2];
  assign cfg_bus.cfg.outside_signal_filter = trig_ff[`TCUC_TRIG_EFLT +: 4];
  assign cfg_bus.cfg.ext_clock_b_enable = trig_ff[`TCUC_TRIG_ECMB];
  assign cfg_bus.cfg.ch1_polarity = trig_ff[`TCUC_TRIG_C1POL];
  assign cfg_bus.cfg.ch2_polarity = trig_ff[`TCUC_TRIG_C2POL];
  assign cfg_bus.cfg.ch1_input_filter = trig_ff[`TCUC_TRIG_C1FLT +: 4];
  assign cfg_bus.cfg.ch2_input_filter = trig_ff[`TCUC_TRIG_C2FLT +: 4];

  tcuc_trig_cond u_cond (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ch1_pin(ch1_pin),
    .ch2_pin(ch2_pin),
    .ext_pin(ext_pin),
    .internal_trigger_line(internal_trigger_line),
    .cfg_if(cfg_bus.cond)
  );

  // ----------------------------------------
  // Clock source selection
  // ----------------------------------------
  logic half_ff;
  logic run_ff;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      half_ff <= 1'b0;
      run_ff <= 1'b0;
    end else begin
      half_ff <= ~half_ff;
      run_ff <= timer_enable_bit;
    end
  end
  // ref_clk stands for the doubled rate; a factor of one halves it
  wire internal_count_clock = bus_presc_is_one ? half_ff : 1'b1;
  wire tcuc_src_e src_mode = tcuc_src_e'(cfg_bus.cfg.ext_clock_b_enable ? TCUC_SRC_EXTB :
                             (slave_mode_select == `TCUC_SMS_EXTA) ? TCUC_SRC_EXTA :
                             TCUC_SRC_INT);
  logic src_tick;
  always_comb begin
    case (src_mode)
      TCUC_SRC_INT: src_tick = internal_count_clock;
      TCUC_SRC_EXTA: src_tick = cfg_bus.ext_tick;
      TCUC_SRC_EXTB: src_tick = cfg_bus.ext_tick;
      default: src_tick = 1'b0;
    endcase
  end
  assign counter_run_sync = run_ff;

  // ----------------------------------------
  // Prescaler and shadows
  // ----------------------------------------
  tcuc_word_t psc_ff;
  tcuc_word_t div_sh_ff;
  tcuc_word_t per_sh_ff;
  tcuc_word_t cnt_ff;
  logic flag_ff;
  logic evt_ff;
  wire psc_ovf = run_ff & src_tick & (psc_ff == div_sh_ff);
  wire counting_tick = psc_ovf;
  wire period_zero = (per_sh_ff == 16'h0000);
  wire edge_mode = (count_alignment_select == `TCUC_ALN_EDGE);
  wire count_up = edge_mode & ~count_direction_bit;
  wire count_down = edge_mode & count_direction_bit;
  wire up_wrap = count_up & (cnt_ff >= per_sh_ff);
  wire down_wrap = count_down & (cnt_ff == 16'h0000);
  // Stopped counter makes no wraps, so a zero period fires only software or slave reset events
  wire hw_wrap = counting_tick & ~period_zero & (up_wrap | down_wrap) & ~wr_cnt;
  wire sw_trig = wr_swev & avs_byteenable[0] & avs_writedata[`TCUC_SWEV_TRIG];
  wire soft_src = ~overflow_source_select & (sw_trig | slave_reset_req);
  wire ovf_evt = ~overflow_event_disable & (hw_wrap | soft_src);
  wire reinit = ovf_evt & ~hw_wrap;

  wire [15:0] nxt_psc = (ovf_evt | psc_ovf) ? 16'h0000 :
                        (run_ff & src_tick) ? psc_ff + 16'h0001 : psc_ff;
  wire [15:0] nxt_div_sh = ovf_evt ? div_ff : div_sh_ff;
  wire [15:0] nxt_per_sh = ~period_buffer_enable ? nxt_per :
                           ovf_evt ? per_ff : per_sh_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      psc_ff <= `TCUC_WORD_RESET;
      div_sh_ff <= `TCUC_WORD_RESET;
      per_sh_ff <= `TCUC_WORD_RESET;
    end else begin
      psc_ff <= nxt_psc;
      div_sh_ff <= nxt_div_sh;
      per_sh_ff <= nxt_per_sh;
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  wire [31:0] cnt_m = tcuc_merge({16'h0000, cnt_ff}, avs_writedata, avs_byteenable);
  logic [15:0] nxt_cnt;
  always_comb begin
    nxt_cnt = cnt_ff;
    if (wr_cnt) begin
      nxt_cnt = cnt_m[15:0];
    end else if (reinit) begin
      nxt_cnt = count_down ? per_sh_ff : 16'h0000;
    end else if (counting_tick && !period_zero) begin
      if (count_up) begin
        nxt_cnt = up_wrap ? 16'h0000 : cnt_ff + 16'h0001;
      end else if (count_down) begin
        nxt_cnt = down_wrap ? per_sh_ff : cnt_ff - 16'h0001;
      end
    end
  end

  // Set beats a same-cycle write-zero clear
  wire flag_clr = wr_stat & avs_byteenable[0] & ~avs_writedata[`TCUC_STAT_FLAG];
  wire nxt_flag = ovf_evt | (flag_ff & ~flag_clr);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= `TCUC_WORD_RESET;
      flag_ff <= 1'b0;
      evt_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      flag_ff <= nxt_flag;
      evt_ff <= ovf_evt;
    end
  end
  assign counter_value = cnt_ff;
  assign overflow_event = evt_ff;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [31:0] rd_mux = (avs_address == `TCUC_OFS_CTRL) ? {24'h000000, ctrl_ff} :
                       (avs_address == `TCUC_OFS_TRIG) ? {4'h0, trig_ff} :
                       (avs_address == `TCUC_OFS_CNT) ? {16'h0000, cnt_ff} :
                       (avs_address == `TCUC_OFS_DIV) ? {16'h0000, div_ff} :
                       (avs_address == `TCUC_OFS_PER) ? {16'h0000, per_ff} :
                       (avs_address == `TCUC_OFS_STAT) ? {31'h0, flag_ff} :
                       32'h00000000;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 32'h00000000;
    end else if (avs_read && !ack_ff) begin
      rdata_ff <= rd_mux;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_run_follows_en: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(timer_enable_bit) |-> !run_ff ##1 run_ff)
    else $error("run signal not one cycle after enable");

  a_zero_period_halt: assert property (@(posedge ref_clk) disable iff (!rstn)
    (period_zero && !wr_cnt && !reinit) |=> (cnt_ff == $past(cnt_ff)))
    else $error("counter moved with zero period");

  a_up_wrap_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    (counting_tick && count_up && !period_zero && cnt_ff == per_sh_ff && !wr_cnt)
    |=> (cnt_ff == 16'h0000) && (flag_ff || $past(overflow_event_disable)))
    else $error("upcount did not wrap to zero with flag");

  a_down_reload: assert property (@(posedge ref_clk) disable iff (!rstn)
    (counting_tick && count_down && !period_zero && cnt_ff == 16'h0000 && !wr_cnt)
    |=> (cnt_ff == $past(per_sh_ff)))
    else $error("downcount did not reload period");

  a_event_blocked: assert property (@(posedge ref_clk) disable iff (!rstn)
    overflow_event_disable |=> !overflow_event)
    else $error("event while disabled");

  a_wrap_only_src: assert property (@(posedge ref_clk) disable iff (!rstn)
    (overflow_source_select && !hw_wrap) |=> !overflow_event)
    else $error("event from non-wrap source");

  a_div_shadow_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ovf_evt |=> $stable(div_sh_ff))
    else $error("prescaler shadow changed without event");

  a_per_buffered: assert property (@(posedge ref_clk) disable iff (!rstn)
    (period_buffer_enable && !ovf_evt) |=> $stable(per_sh_ff))
    else $error("buffered period changed without event");

  a_cnt_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wr_cnt && avs_byteenable[1:0] == 2'h3) |=> (counter_value == $past(avs_writedata[15:0])))
    else $error("counter write not applied");

  a_tick_spacing: assert property (@(posedge ref_clk) disable iff (!rstn)
    (counting_tick && div_sh_ff == 16'h0001 && !ovf_evt) |=> !counting_tick)
    else $error("prescaler ticked too early");
endmodule : tcuc_top

// file: test/tcuc_pin_src.sv
// Far-side pin source: other timers' trigger lines and the outside pins.
// Assumes ref_clk is the kernel clock; pins rest low between bursts.
`timescale 1ns/1ps
module tcuc_pin_src (
  input wire logic ref_clk,
  output logic ch1_pin,
  output logic ch2_pin,
  output logic ext_pin,
  output logic [3:0] internal_trigger_line
);
  logic [6:0] pins = 7'h00;
  assign internal_trigger_line = pins[3:0];
  assign ch1_pin = pins[4];
  assign ch2_pin = pins[5];
  assign ext_pin = pins[6];
  // ----------------------------------------
  // Burst source
  // ----------------------------------------
  // Slow edges so the synchroniser never merges two of them
  task automatic burst(input int sel, input int n);
    repeat (n) begin
      repeat (6) @(posedge ref_clk);
      pins[sel] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      pins[sel] <= 1'b0;
    end
  endtask : burst
endmodule : tcuc_pin_src

// file: test/timer_clock_and_upcount_core_test.sv
// Bench for the timer core: register tasks, counting and clock sources.
// Assumes the map header on the include path and the pin source model.
`timescale 1ns/1ps
`include "tcuc_map.svh"
module timer_clock_and_upcount_core_test;
  import tcuc_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic bus_presc_is_one = 1'b0;
  logic slave_reset_req = 1'b0;
  logic ch1_pin, ch2_pin, ext_pin;
  logic [3:0] internal_trigger_line;
  tcuc_word_t counter_value;
  logic overflow_event, counter_run_sync;
  logic [31:0] rd;
  int miscompares = 0;
  int tests_run = 0;
  int n;
  int sel;
  initial forever #5 ref_clk = ~ref_clk;
  tcuc_pin_src src (.ref_clk(ref_clk), .ch1_pin(ch1_pin), .ch2_pin(ch2_pin),
    .ext_pin(ext_pin), .internal_trigger_line(internal_trigger_line));
  tcuc_top dut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus_presc_is_one(bus_presc_is_one),
    .ch1_pin(ch1_pin), .ch2_pin(ch2_pin), .ext_pin(ext_pin),
    .internal_trigger_line(internal_trigger_line), .slave_reset_req(slave_reset_req),
    .counter_value(counter_value), .overflow_event(overflow_event),
    .counter_run_sync(counter_run_sync));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // An edge passes first, so back-to-back calls never drive twice at once
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 20) begin
      miscompares++;
      end_sim();
    end
  endtask : bus
  task automatic wait_ev(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (overflow_event !== 1'b1 && c < 300);
    if (c >= 300) begin
      miscompares++;
      end_sim();
    end
  endtask : wait_ev
  task automatic count_ev(input int len, output int c);
    c = 0;
    repeat (len) begin
      @(posedge ref_clk);
      if (overflow_event === 1'b1) c++;
    end
  endtask : count_ev
  task automatic pulse_src(input logic sw);
    if (sw) bus(1'b1, `TCUC_OFS_SWEV, 32'h1);
    else begin
      @(posedge ref_clk);
      slave_reset_req <= 1'b1;
      @(posedge ref_clk);
      slave_reset_req <= 1'b0;
    end
  endtask : pulse_src
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b1, 3'h7, 32'hffffffff);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, i[2:0], 32'h0);
      check("reset word", 32'h0, rd);
    end
    bus(1'b1, `TCUC_OFS_DIV, 32'h2);
    bus(1'b1, `TCUC_OFS_PER, 32'h4);
    bus(1'b1, `TCUC_OFS_CTRL, 32'h1);
    @(posedge ref_clk);
    check("run early", 32'h0, {31'h0, counter_run_sync});
    @(posedge ref_clk);
    check("run", 32'h1, {31'h0, counter_run_sync});
    wait_ev(n);
    wait_ev(n);
    check("period", 32'd15, n);
    bus_presc_is_one <= 1'b1;
    wait_ev(n);
    wait_ev(n);
    check("slow period", 32'd30, n);
    bus_presc_is_one <= 1'b0;
    bus(1'b1, `TCUC_OFS_DIV, 32'h0);
    wait_ev(n);
    wait_ev(n);
    check("new div", 32'd5, n);
    bus(1'b1, `TCUC_OFS_CTRL, 32'h81);
    bus(1'b1, `TCUC_OFS_PER, 32'h9);
    wait_ev(n);
    wait_ev(n);
    check("buffered per", 32'd10, n);
    bus(1'b0, `TCUC_OFS_STAT, 32'h0);
    check("flag", 32'h1, rd);
    bus(1'b1, `TCUC_OFS_CTRL, 32'h83);
    bus(1'b1, `TCUC_OFS_STAT, 32'h0);
    count_ev(40, n);
    check("events off", 32'h0, n);
    bus(1'b0, `TCUC_OFS_STAT, 32'h0);
    check("flag off", 32'h0, rd);
    bus(1'b1, `TCUC_OFS_PER, 32'hffff);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `TCUC_OFS_CTRL, (i > 1) ? 32'h5 : 32'h1);
      count_ev(4, n);
      pulse_src(i[0]);
      count_ev(6, n);
      check("event source", (i > 1) ? 32'h0 : 32'h1, n);
    end
    bus(1'b1, `TCUC_OFS_CTRL, 32'h0);
    bus(1'b1, `TCUC_OFS_CNT, 32'h1234);
    bus(1'b0, `TCUC_OFS_CNT, 32'h0);
    check("cnt write", 32'h1234, rd);
    bus(1'b1, `TCUC_OFS_PER, 32'h0);
    bus(1'b1, `TCUC_OFS_CNT, 32'h0);
    bus(1'b1, `TCUC_OFS_CTRL, 32'h1);
    repeat (20) @(posedge ref_clk);
    check("zero period", 32'h0, {16'h0, counter_value});
    for (int i = 0; i < 10; i++) begin
      sel = (i < 4) ? i : (i < 6) ? 4 : (i == 6) ? 5 : 6;
      bus(1'b1, `TCUC_OFS_CTRL, 32'h0);
      bus(1'b1, `TCUC_OFS_TRIG, (i == 9) ? 32'h177 : (i < 8) ? (32'h7 | (i << 4)) : 32'h4000);
      bus(1'b1, `TCUC_OFS_PER, 32'hffff);
      bus(1'b1, `TCUC_OFS_CNT, 32'h0);
      bus(1'b1, `TCUC_OFS_CTRL, 32'h1);
      src.burst(sel, 4);
      repeat (20) @(posedge ref_clk);
      bus(1'b0, `TCUC_OFS_CNT, 32'h0);
      // Both edges double the count; divide by two halves it
      n = (i == 4) ? 8 : (i == 9) ? 2 : 4;
      check("ext count", n, rd);
    end
    bus(1'b1, `TCUC_OFS_TRIG, 32'h0);
    bus(1'b1, `TCUC_OFS_PER, 32'h3);
    bus(1'b1, `TCUC_OFS_CTRL, 32'h9);
    wait_ev(n);
    wait_ev(n);
    check("down period", 32'd4, n);
    end_sim();
  end
endmodule : timer_clock_and_upcount_core_test
